// ===== timer_irq_event_regs_tb.sv
/*
 * Self-checking bench of the timer interrupt, flag and software event
 * registers, with directed corner cases and LFSR-driven random steps.
 * Assumes tmev_pkg, tmev_cfg.svh and tmev_regs are compiled before it.
 */
`default_nettype none
`include "tmev_cfg.svh"
module timer_irq_event_regs_tb
    import tmev_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic regSel = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [7:0] regAddr = 8'h00;
    tmev_size_t regSize = TMEV_SIZE_HALF;
    logic [31:0] regWdata = 32'h0;
    logic [31:0] regRdata;
    logic [15:0] counterValue = 16'h0000;
    logic chanInputMode = 1'b0;
    logic captureEvent = 1'b0;
    logic compareEvent = 1'b0;
    logic counterWrapEvent = 1'b0;
    logic updateDisable = 1'b0;
    logic updateSourceSelect = 1'b0;
    logic timerIrq, updateEvent, counterClear, chanEventPulse;
    logic [15:0] captureValue;
    int num_errors = 0;
    int total_checks = 0;
    logic [15:0] seed = 16'h0051;
    logic [15:0] expFlags = 16'h0000;
    logic [1:0] expEn = 2'h0;
    logic [15:0] expCap = 16'h0000;

    tmev_regs #(.CNT_W(16)) u_dut (.sys_clk(sys_clk), .rstn(rstn),
        .regSel(regSel), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regSize(regSize), .regWdata(regWdata),
        .regRdata(regRdata), .counterValue(counterValue),
        .chanInputMode(chanInputMode), .captureEvent(captureEvent),
        .compareEvent(compareEvent), .counterWrapEvent(counterWrapEvent),
        .updateDisable(updateDisable),
        .updateSourceSelect(updateSourceSelect), .timerIrq(timerIrq),
        .updateEvent(updateEvent), .counterClear(counterClear),
        .chanEventPulse(chanEventPulse), .captureValue(captureValue));

    always #20 sys_clk = ~sys_clk;

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    function automatic logic [31:0] rdExp(input logic [7:0] a);
        case (a)
            `TMEV_OFS_INT_ENABLE: return {30'h0, expEn};
            `TMEV_OFS_INT_FLAGS: return {16'h0, expFlags};
            `TMEV_OFS_CAPTURE: return {16'h0, expCap};
            default: return 32'h0;
        endcase
    endfunction : rdExp

    task automatic test_done();
        if (num_errors == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Request is held through the taking edge, then released by NBA.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input tmev_size_t sz);
        @(posedge sys_clk);
        regSel <= 1'b1;
        regWrite <= wr;
        regRead <= ~wr;
        regAddr <= a;
        regWdata <= d;
        regSize <= sz;
        @(posedge sys_clk);
        regSel <= 1'b0;
        regWrite <= 1'b0;
        regRead <= 1'b0;
        @(negedge sys_clk);
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input tmev_size_t sz);
        bus(1'b1, a, d, sz);
        if (sz != TMEV_SIZE_BYTE && a == `TMEV_OFS_INT_ENABLE)
            expEn = d[1:0];
        if (sz != TMEV_SIZE_BYTE && a == `TMEV_OFS_INT_FLAGS)
            expFlags = expFlags & d[15:0];
    endtask : wr

    task automatic rd(input logic [7:0] a, input tmev_size_t sz);
        bus(1'b0, a, 32'h0, sz);
        chk(regRdata, rdExp(a));
        if (a == `TMEV_OFS_CAPTURE && chanInputMode)
            expFlags[1] = 1'b0;
    endtask : rd

    task automatic chev(input logic cap);
        if (cap) begin
            if (expFlags[1])
                expFlags[9] = 1'b1;
            expCap = counterValue;
        end
        expFlags[1] = 1'b1;
        chk(32'(captureValue), 32'(expCap));
    endtask : chev

    task automatic sw(input logic [1:0] d);
        wr(`TMEV_OFS_SW_EVENT, {30'h0, d}, TMEV_SIZE_WORD);
        chk(32'(counterClear), 32'(d[0]));
        chk(32'(updateEvent), 32'(d[0] & ~updateDisable));
        chk(32'(chanEventPulse), 32'(d[1]));
        if (d[0] && !updateDisable && !updateSourceSelect)
            expFlags[0] = 1'b1;
        if (d[1])
            chev(chanInputMode);
    endtask : sw

    task automatic hw(input logic [1:0] k);
        logic hit;
        @(posedge sys_clk);
        // The mode that step drives lands at the edge before this one.
        hit = (k == {1'b0, ~chanInputMode});
        captureEvent <= (k == 2'h0);
        compareEvent <= (k == 2'h1);
        counterWrapEvent <= (k == 2'h2);
        @(posedge sys_clk);
        captureEvent <= 1'b0;
        compareEvent <= 1'b0;
        counterWrapEvent <= 1'b0;
        @(negedge sys_clk);
        chk(32'(updateEvent), 32'(k == 2'h2 && !updateDisable));
        chk(32'(chanEventPulse), 32'(hit));
        chk(32'(counterClear), 32'h0);
        if (k == 2'h2 && !updateDisable)
            expFlags[0] = 1'b1;
        if (hit)
            chev(chanInputMode);
    endtask : hw

    // Bits 12..14 of r pick the modes; the rest feed data and counter.
    task automatic step(input logic [2:0] op, input logic [15:0] r);
        @(posedge sys_clk);
        chanInputMode <= r[12];
        updateDisable <= r[13];
        updateSourceSelect <= r[14];
        counterValue <= {r[7:0], r[15:8]};
        case (op)
            3'h0: wr(`TMEV_OFS_INT_ENABLE, {16'hFFFF, 14'h0, r[1:0]},
                     r[3] ? TMEV_SIZE_WORD : TMEV_SIZE_HALF);
            3'h1: sw(r[1:0]);
            3'h2, 3'h3, 3'h4: hw(op[1:0] - 2'h2);
            3'h5: wr(`TMEV_OFS_INT_FLAGS, {16'h0, r & 16'h0203},
                     TMEV_SIZE_WORD);
            3'h6: rd(`TMEV_OFS_CAPTURE, TMEV_SIZE_WORD);
            default: rd(8'h20, TMEV_SIZE_HALF);
        endcase
        @(negedge sys_clk);
        chk(32'(timerIrq), 32'(|(expFlags[1:0] & expEn)));
        rd(`TMEV_OFS_INT_FLAGS, TMEV_SIZE_HALF);
    endtask : step

    initial begin
        repeat (20000) @(posedge sys_clk);
        num_errors++;
        test_done();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        rd(`TMEV_OFS_INT_ENABLE, TMEV_SIZE_HALF);
        rd(`TMEV_OFS_SW_EVENT, TMEV_SIZE_WORD);
        rd(`TMEV_OFS_CAPTURE, TMEV_SIZE_HALF);
        wr(`TMEV_OFS_INT_ENABLE, 32'h3, TMEV_SIZE_BYTE);
        rd(`TMEV_OFS_INT_ENABLE, TMEV_SIZE_WORD);
        step(3'h0, 16'h0003);
        step(3'h1, 16'h0001);
        step(3'h1, 16'h2001);
        step(3'h5, 16'h0000);
        step(3'h1, 16'h4001);
        step(3'h4, 16'h2000);
        step(3'h4, 16'h4000);
        step(3'h1, 16'h1002);
        step(3'h1, 16'h1002);
        step(3'h6, 16'h1000);
        step(3'h5, 16'h0203);
        step(3'h5, 16'h0000);
        step(3'h3, 16'h0000);
        step(3'h2, 16'h1000);
        step(3'h2, 16'h1000);
        step(3'h2, 16'h0000);
        step(3'h3, 16'h1000);
        // A reset in mid-run must drop every flag, enable and capture.
        @(posedge sys_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        expFlags = 16'h0000;
        expEn = 2'h0;
        expCap = 16'h0000;
        rd(`TMEV_OFS_INT_FLAGS, TMEV_SIZE_WORD);
        rd(`TMEV_OFS_INT_ENABLE, TMEV_SIZE_HALF);
        rd(`TMEV_OFS_CAPTURE, TMEV_SIZE_WORD);
        chk(32'(timerIrq), 32'h0);
        for (int i = 0; i < 200; i++) begin
            seed = lfsr(seed);
            step(seed[10:8], seed);
        end
        test_done();
    end
endmodule : timer_irq_event_regs_tb
`default_nettype wire

// ===== tmev_cfg.svh
/*
 * Constants of the timer interrupt and software event block: register
 * offsets, field positions and reset values.
 * Assumes it is included by bare name wherever these figures are needed.
 */
//
// Contract
// - Enable register bit 1 enables channel-zero interrupt, bit 0 update.
// - Over-capture flag bit 9 sets on input capture while channel flag set.
// - Flags set only by hardware; write zero clears, write one keeps.
// - Channel flag bit 1 sets on capture in input, compare in output.
// - In input mode reading the capture value clears the channel flag.
// - Update flag bit 0 sets on update event, holds until cleared.
// - Software event bit 1 makes a channel event and clears itself.
// - Software channel event in input mode captures counter, may over-capture.
// - Software event bit 0 makes update, clears counter and prescaler.
// - Enable register accepts half-word and word accesses.
// - With update disable set, software update only reinitialises counter.
// - With update source set, software update raises no update flag.
`ifndef TMEV_CFG_SVH
`define TMEV_CFG_SVH

`define TMEV_OFS_INT_ENABLE 8'h0C
`define TMEV_OFS_INT_FLAGS 8'h10
`define TMEV_OFS_SW_EVENT 8'h14
`define TMEV_OFS_CAPTURE 8'h34

`define TMEV_BIT_UPDATE 0
`define TMEV_BIT_CHAN 1
`define TMEV_BIT_OVERCAP 9

`define TMEV_FLG_UPDATE 0
`define TMEV_FLG_CHAN 1
`define TMEV_FLG_OVERCAP 2

`define TMEV_RST_ENABLE 2'h0
`define TMEV_RST_FLAG 1'h0
`define TMEV_RST_CAPTURE 16'h0000

`endif

// ===== tmev_pkg.sv
/*
 * Types shared by the timer interrupt and software event block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none

package tmev_pkg;

    // Access width presented by the peripheral bus with each access.
    typedef enum logic [1:0] {
        TMEV_SIZE_BYTE = 2'h0,
        TMEV_SIZE_HALF = 2'h1,
        TMEV_SIZE_WORD = 2'h2
    } tmev_size_t;

    // Internal flag vector: update, channel zero, over-capture.
    typedef logic [2:0] tmev_flags_t;

endpackage : tmev_pkg

`default_nettype wire

// ===== tmev_regs.sv
/*
 * Interrupt enable, interrupt flag and software event registers of a
 * general-purpose timer with one capture/compare channel, plus the
 * channel-zero capture value register that the flags depend on.
 * Assumes the counter, prescaler and control registers run on sys_clk
 * and hand over their events as one-cycle pulses on the same clock.
 */
`default_nettype none

`include "tmev_cfg.svh"

module tmev_regs
    import tmev_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic regSel,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [7:0] regAddr,
    input wire tmev_size_t regSize,
    input wire logic [31:0] regWdata,
    output logic [31:0] regRdata,
    input wire logic [CNT_W-1:0] counterValue,
    input wire logic chanInputMode,
    input wire logic captureEvent,
    input wire logic compareEvent,
    input wire logic counterWrapEvent,
    input wire logic updateDisable,
    input wire logic updateSourceSelect,
    output logic timerIrq,
    output logic updateEvent,
    output logic counterClear,
    output logic chanEventPulse,
    output logic [CNT_W-1:0] captureValue
);

    logic [1:0] enables;
    tmev_flags_t flags;
    tmev_flags_t setVec;
    tmev_flags_t clrVec;

    // Byte accesses are not supported by these registers and are dropped.
    wire accOk = (regSize == TMEV_SIZE_HALF) || (regSize == TMEV_SIZE_WORD);
    wire wrEn = regSel && regWrite && accOk;
    wire rdEn = regSel && regRead && accOk;

    wire hitEnable = (regAddr == `TMEV_OFS_INT_ENABLE);
    wire hitFlags = (regAddr == `TMEV_OFS_INT_FLAGS);
    wire hitSwEvent = (regAddr == `TMEV_OFS_SW_EVENT);
    wire hitCapture = (regAddr == `TMEV_OFS_CAPTURE);

    wire wrEnable = wrEn && hitEnable;
    wire wrFlags = wrEn && hitFlags;
    wire wrSwEvent = wrEn && hitSwEvent;
    wire rdCapture = rdEn && hitCapture;

    // Software triggers act in the write cycle and are never stored, so
    // the trigger bits read back as zero.
    wire swChan = wrSwEvent && regWdata[`TMEV_BIT_CHAN];
    wire swUpd = wrSwEvent && regWdata[`TMEV_BIT_UPDATE];

    // Channel event: capture in input mode, compare in output mode.
    wire hwChan = chanInputMode ? captureEvent : compareEvent;
    wire chanEv = hwChan || swChan;
    wire doCapture = chanEv && chanInputMode;

    // Update events are suppressed as a whole by the disable bit.
    wire swUpdEv = swUpd && !updateDisable;
    wire updEv = (counterWrapEvent && !updateDisable) || swUpdEv;
    // The source select keeps software updates off the flag.
    wire updFlagSet = (counterWrapEvent && !updateDisable) ||
        (swUpdEv && !updateSourceSelect);

    assign setVec[`TMEV_FLG_UPDATE] = updFlagSet;
    assign setVec[`TMEV_FLG_CHAN] = chanEv;
    assign setVec[`TMEV_FLG_OVERCAP] =
        doCapture && flags[`TMEV_FLG_CHAN];

    // Writing zero clears a flag, writing one leaves it alone.
    assign clrVec[`TMEV_FLG_UPDATE] =
        wrFlags && !regWdata[`TMEV_BIT_UPDATE];
    assign clrVec[`TMEV_FLG_CHAN] =
        (wrFlags && !regWdata[`TMEV_BIT_CHAN]) ||
        (rdCapture && chanInputMode);
    assign clrVec[`TMEV_FLG_OVERCAP] =
        wrFlags && !regWdata[`TMEV_BIT_OVERCAP];

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            tmev_sticky_flag u_flag (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .setEvent(setVec[gi]),
                .clearReq(clrVec[gi]),
                .flag(flags[gi])
            );
        end
    endgenerate

    wire [15:0] flagsView = {6'h00, flags[`TMEV_FLG_OVERCAP], 7'h00,
        flags[`TMEV_FLG_CHAN], flags[`TMEV_FLG_UPDATE]};
    wire [31:0] rdMux = !rdEn ? 32'h00000000 :
        hitEnable ? {30'h00000000, enables} :
        hitFlags ? {16'h0000, flagsView} :
        hitCapture ? 32'(captureValue) :
        32'h00000000;

    wire anyPending = |(flags[1:0] & enables);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            enables <= `TMEV_RST_ENABLE;
        end else if (wrEnable) begin
            enables <= regWdata[1:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            captureValue <= CNT_W'(`TMEV_RST_CAPTURE);
        end else if (doCapture) begin
            captureValue <= counterValue;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            regRdata <= 32'h00000000;
            timerIrq <= 1'b0;
            updateEvent <= 1'b0;
            counterClear <= 1'b0;
            chanEventPulse <= 1'b0;
        end else begin
            regRdata <= rdMux;
            timerIrq <= anyPending;
            updateEvent <= updEv;
            // The counter is reinitialised even when updates are disabled.
            counterClear <= swUpd;
            chanEventPulse <= chanEv;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);

    sequence s_sw_chan_write;
        swChan && !clrVec[`TMEV_FLG_CHAN];
    endsequence

    sequence s_chan_seen;
        flags[`TMEV_FLG_CHAN] && chanEventPulse;
    endsequence

    sequence s_sw_upd_write;
        swUpd;
    endsequence

    sequence s_clear_pulse;
        counterClear ##1 !counterClear || swUpd;
    endsequence

    property p_enable_write;
        wrEnable |=> enables == $past(regWdata[1:0]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("enable register did not take written value");

    property p_enable_size;
        regSel && regWrite && hitEnable && regSize == TMEV_SIZE_HALF
            |=> enables == $past(regWdata[1:0]);
    endproperty
    a_enable_size: assert property (p_enable_size)
        else $error("half-word write to enable register was lost");

    property p_overcap;
        doCapture && flags[`TMEV_FLG_CHAN]
            |=> flags[`TMEV_FLG_OVERCAP];
    endproperty
    a_overcap: assert property (p_overcap)
        else $error("over-capture flag not set on repeated capture");

    property p_write_one_keeps;
        wrFlags && regWdata[`TMEV_BIT_UPDATE] && !updFlagSet
            |=> $stable(flags[`TMEV_FLG_UPDATE]);
    endproperty
    a_write_one_keeps: assert property (p_write_one_keeps)
        else $error("writing one changed the update flag");

    property p_write_zero_clears;
        wrFlags && !regWdata[`TMEV_BIT_OVERCAP] &&
            !setVec[`TMEV_FLG_OVERCAP] |=> !flags[`TMEV_FLG_OVERCAP];
    endproperty
    a_write_zero_clears: assert property (p_write_zero_clears)
        else $error("writing zero did not clear over-capture flag");

    property p_hw_chan;
        hwChan |=> flags[`TMEV_FLG_CHAN];
    endproperty
    a_hw_chan: assert property (p_hw_chan)
        else $error("channel flag not set on channel event");

    property p_read_clears;
        rdCapture && chanInputMode && !chanEv
            |=> !flags[`TMEV_FLG_CHAN];
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("capture read did not clear channel flag");

    property p_update_holds;
        flags[`TMEV_FLG_UPDATE] && !clrVec[`TMEV_FLG_UPDATE]
            |=> flags[`TMEV_FLG_UPDATE];
    endproperty
    a_update_holds: assert property (p_update_holds)
        else $error("update flag dropped without a clear");

    property p_sw_chan;
        s_sw_chan_write |=> s_chan_seen;
    endproperty
    a_sw_chan: assert property (p_sw_chan)
        else $error("software channel event had no effect");

    property p_sw_capture;
        swChan && chanInputMode |=> captureValue == $past(counterValue);
    endproperty
    a_sw_capture: assert property (p_sw_capture)
        else $error("software channel event did not capture counter");

    property p_sw_upd;
        s_sw_upd_write |=> s_clear_pulse;
    endproperty
    a_sw_upd: assert property (p_sw_upd)
        else $error("software update did not pulse counter clear");

    property p_upd_disable;
        swUpd && updateDisable |=> !updateEvent && counterClear;
    endproperty
    a_upd_disable: assert property (p_upd_disable)
        else $error("disabled update still produced an update event");

    property p_upd_source;
        swUpd && updateSourceSelect && !counterWrapEvent
            |=> $stable(flags[`TMEV_FLG_UPDATE]);
    endproperty
    a_upd_source: assert property (p_upd_source)
        else $error("software update set flag with source select on");

    // Built from the flags and enables directly, not from anyPending, so a
    // wrong pairing of flag and enable bit is caught.
    property p_irq;
        timerIrq == $past((flags[`TMEV_FLG_CHAN] && enables[1]) ||
            (flags[`TMEV_FLG_UPDATE] && enables[0]));
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt output does not follow enabled flags");

endmodule : tmev_regs

`default_nettype wire

// ===== tmev_sticky_flag.sv
/*
 * One sticky status flag: hardware sets it, a clear request drops it.
 * Assumes set and clear come from logic on sys_clk.
 */
`default_nettype none

`include "tmev_cfg.svh"

module tmev_sticky_flag
    import tmev_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic setEvent,
    input wire logic clearReq,
    output logic flag
);

    // A set in the cycle of a clear wins, so no event is ever lost.
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            flag <= `TMEV_RST_FLAG;
        end else if (setEvent) begin
            flag <= 1'b1;
        end else if (clearReq) begin
            flag <= 1'b0;
        end
    end

endmodule : tmev_sticky_flag

`default_nettype wire
